/* src/rsc_pkg.sv */
package rsc_pkg;
    // register map
    localparam logic [31:0] RSC_STRAP_CFG_OFS  = 32'h0000_0000;
    localparam logic [31:0] RSC_STATUS_OFS     = 32'h0000_0004;
    localparam logic [31:0] RSC_ADDR_MASK      = 32'h0000_00FC;
    // strap field layout
    localparam int          RSC_STRAP_W        = 25;
    localparam int          RSC_REMAP_BIT      = 31;
    // reset values: undriven straps read high, remap bit high
    localparam logic [31:0] RSC_CFG_RESET      = 32'hFFFF_FFFF;
    localparam logic [24:0] RSC_STRAP_ONES     = 25'h1FF_FFFF;
    // status bit positions
    localparam int          RSC_ST_CAPTURED    = 0;
    localparam int          RSC_ST_SAMPLING    = 1;
    // capture sequencer states
    typedef enum logic [2:0] {
        RSC_SAMPLE  = 3'b001,
        RSC_CAPTURE = 3'b010,
        RSC_RUN     = 3'b100
    } rsc_state_t;
endpackage : rsc_pkg

/* src/rsc_sync3.sv */
`timescale 1ns/1ps
// three-stage synchroniser; change accepted when stages two and three agree
module rsc_sync3 #(
    parameter int W = 1
) (
    // clocking
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] agree;

    // first stage feeds only the second
    assign agree = ~(s2_q ^ s3_q);
    assign dout  = out_q;

    // reset to ones: undriven pins default high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            out_q <= '1;
        end else if (ce) begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= (agree & s3_q) | (~agree & out_q);
        end
    end
endmodule : rsc_sync3

/* src/rsc_strap_capture.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rsc_strap_capture
    import rsc_pkg::*;
(
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // pll lock
    input  wire logic                      pll_lock_indication,
    // strap address pins, three-signal form
    input  wire logic [rsc_pkg::RSC_STRAP_W-1:0] strap_address_pins_i,
    output logic      [rsc_pkg::RSC_STRAP_W-1:0] strap_address_pins_o,
    output logic      [rsc_pkg::RSC_STRAP_W-1:0] strap_address_pins_oe,
    // expansion bus address from the bus controller
    input  wire logic [rsc_pkg::RSC_STRAP_W-1:0] exp_addr,
    // configuration out
    output logic      [31:0]               strap_cfg,
    output logic                           strap_captured
);
    import rsc_pkg::*;

    rsc_state_t        state_q;
    rsc_state_t        state_d;
    logic [31:0]       cfg_q;
    logic [31:0]       cfg_d;
    logic [24:0]       pins_s;
    logic              unlock_s;
    logic              lock_s;
    logic              rdy_q;
    logic [31:0]       rdata_q;
    logic              err_q;
    logic [24:0]       pin_o_q;
    logic [24:0]       pin_oe_q;
    logic              cap_q;
    logic              setup;
    logic              hit_cfg;
    logic              hit_st;
    logic              hit_any;
    logic              wr_cfg;
    logic [31:0]       rd_mux;
    logic              sampling;

    // is this address word one of ours
    function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ofs);
        return ((a & RSC_ADDR_MASK) == ofs) && (a[1:0] == 2'h0)
               && ((a & ~RSC_ADDR_MASK) == 32'h0);
    endfunction : addr_hit

    // strap pins synchronised, defaulting high while nothing drives them
    rsc_sync3 #(.W(RSC_STRAP_W)) u_pin_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .din   (strap_address_pins_i),
        .dout  (pins_s)
    );

    // lock is a pin too; filtered inverted so that the filter's reset value
    // reads as unlocked and no false lock lands right after reset
    rsc_sync3 #(.W(1)) u_lock_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .din   (~pll_lock_indication),
        .dout  (unlock_s)
    );
    assign lock_s = ~unlock_s;

    // sequencer: sample while unlocked, capture once, then run
    always_comb begin
        state_d = state_q;
        case (state_q)
            RSC_SAMPLE: begin
                if (lock_s) begin
                    state_d = RSC_CAPTURE;
                end
            end
            RSC_CAPTURE: state_d = RSC_RUN;
            RSC_RUN:     state_d = RSC_RUN;
            default:     state_d = RSC_SAMPLE;
        endcase
    end

    assign sampling = (state_q == RSC_SAMPLE);

    // sequencer checks
    // no lock seen, so the pins must stay inputs
    chk_lock_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && sampling && !lock_s) |=> sampling)
        else $error("sampling left while pll unlocked");

    // the first enabled cycle with lock seen moves to capture
    chk_capture_next: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && sampling && lock_s) |=> (state_q == RSC_CAPTURE))
        else $error("capture did not follow lock");

    // the sequencer never holds two states at once
    chk_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(state_q))
        else $error("sequencer state not one-hot");

    // capture lasts a single enabled cycle
    chk_capture_once: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state_q == RSC_CAPTURE) |=> (state_q == RSC_RUN))
        else $error("capture state held too long");

    // only a reset leaves run, so straps are taken once per reset
    chk_run_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == RSC_RUN) |=> (state_q == RSC_RUN))
        else $error("run state left without reset");

    // apb decode
    assign setup   = psel && !penable;
    assign hit_cfg = addr_hit(paddr, RSC_STRAP_CFG_OFS);
    assign hit_st  = addr_hit(paddr, RSC_STATUS_OFS);
    assign hit_any = hit_cfg || hit_st;
    assign wr_cfg  = psel && penable && rdy_q && pwrite && hit_cfg && (state_q == RSC_RUN);
    assign rd_mux  = hit_cfg ? cfg_q :
                     hit_st  ? {30'h0, sampling, cap_q} : 32'h0;

    // config register: capture from pins, else software write
    always_comb begin
        cfg_d = cfg_q;
        if (sampling) begin
            cfg_d = {cfg_q[31:25], pins_s};
        end else if (state_q == RSC_CAPTURE) begin
            cfg_d = {cfg_q[31:25], pins_s};
        end else if (wr_cfg) begin
            cfg_d = pwdata;
        end
    end

    // state and configuration storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RSC_SAMPLE;
            cfg_q   <= RSC_CFG_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
            cfg_q   <= cfg_d;
        end
    end

    // configuration checks
    // while sampling the register follows the filtered pins
    chk_cfg_track: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && sampling) |=> (cfg_q[24:0] == $past(pins_s)))
        else $error("strap bits not following pins");

    // bits above the straps are never sampled, so they stay high until a write in run
    chk_reset_high: assert property (@(posedge pclk) disable iff (!presetn)
        sampling |-> (cfg_q[31:25] == 7'h7F))
        else $error("upper config bits not high");

    // the capture cycle stores what the filter shows
    chk_capture_val: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state_q == RSC_CAPTURE) |=> (cfg_q[24:0] == $past(pins_s)))
        else $error("captured strap value wrong");

    // early bus writes are dropped, so upper bits hold
    chk_upper_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state_q != RSC_RUN) |=> (cfg_q[31:25] == $past(cfg_q[31:25])))
        else $error("upper config bits changed before run");

    // a write in run lands on the next edge
    chk_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && wr_cfg) |=> (strap_cfg == $past(pwdata)))
        else $error("software write lost");

    // without a write the value holds in run
    chk_cfg_stable: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == RSC_RUN && !wr_cfg) |=> $stable(cfg_q))
        else $error("config changed without write");

    // pins: inputs while sampling, follow the bus afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe_q <= 25'h000_0000;
            pin_o_q  <= 25'h000_0000;
            cap_q    <= 1'b0;
        end else if (clk_en) begin
            pin_oe_q <= (state_d == RSC_RUN) ? RSC_STRAP_ONES : 25'h000_0000;
            pin_o_q  <= exp_addr;
            cap_q    <= cap_q || (state_q == RSC_CAPTURE);
        end
    end

    // pin and captured flag checks
    // pins stay inputs for the whole sampling phase
    chk_pins_input: assert property (@(posedge pclk) disable iff (!presetn)
        sampling |-> (strap_address_pins_oe == 25'h000_0000))
        else $error("strap pins driven while sampling");

    // once captured the pins drive again
    chk_pins_released: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state_q == RSC_CAPTURE) |=> (strap_address_pins_oe == RSC_STRAP_ONES))
        else $error("pins not returned to outputs");

    // in run every pin drives
    chk_run_drives: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == RSC_RUN) |-> (strap_address_pins_oe == RSC_STRAP_ONES))
        else $error("pins not driving in run");

    // the pins switch together, never a partial mix
    chk_oe_all_none: assert property (@(posedge pclk) disable iff (!presetn)
        (strap_address_pins_oe == 25'h000_0000) || (strap_address_pins_oe == RSC_STRAP_ONES))
        else $error("pin enables split");

    // the bus address reaches the pins one cycle late
    chk_pin_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state_q == RSC_RUN) |=> (strap_address_pins_o == $past(exp_addr)))
        else $error("bus address not on pins");

    // the status flag marks the run state exactly
    chk_captured_flag: assert property (@(posedge pclk) disable iff (!presetn)
        strap_captured == (state_q == RSC_RUN))
        else $error("captured flag wrong");

    // the flag only falls with a reset
    chk_captured_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        strap_captured |=> strap_captured)
        else $error("captured flag fell");

    // apb: no wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (clk_en) begin
            rdy_q   <= setup;
            err_q   <= setup && !hit_any;
            rdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // outputs come straight from their flops
    assign prdata                = rdata_q;
    assign pready                = rdy_q;
    assign pslverr               = err_q;
    assign strap_address_pins_o  = pin_o_q;
    assign strap_address_pins_oe = pin_oe_q;
    assign strap_cfg             = cfg_q;
    assign strap_captured        = cap_q;

    // bus checks
    // the answer comes one cycle after setup
    chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup) |=> pready)
        else $error("pready late");

    // pready is a single-cycle pulse
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && pready) |=> !pready)
        else $error("pready held too long");

    // no answer without a selected setup
    chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !psel) |=> !pready)
        else $error("pready without request");

    // an unmapped word is refused with an error and no data
    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup && !hit_any) |=> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not refused");

    // mapped words answer without error
    chk_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup && hit_any) |=> !pslverr)
        else $error("mapped access refused");

    // writes return no read data
    chk_rdata_write: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup && pwrite) |=> (prdata == 32'h0000_0000))
        else $error("read data on a write");

    // a config read returns the stored word
    chk_cfg_read: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup && !pwrite && hit_cfg) |=> (prdata == $past(cfg_q)))
        else $error("config read wrong");

    // a status read shows the sampling phase
    chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setup && !pwrite && hit_st) |=> (prdata[1] == $past(sampling)))
        else $error("status sampling bit wrong");

    // main scenarios
    cov_capture:   cover property (@(posedge pclk) state_q == RSC_CAPTURE);
    cov_write:     cover property (@(posedge pclk) wr_cfg);
    cov_unmapped:  cover property (@(posedge pclk) pready && pslverr);
    cov_strap_low: cover property (@(posedge pclk) (state_q == RSC_CAPTURE) && !(&pins_s));
    cov_frozen:    cover property (@(posedge pclk) (state_q == RSC_RUN) && !clk_en);
endmodule : rsc_strap_capture

/* bench/rsc_board_model.sv */
`timescale 1ns/1ps
// board side of the strap pins: pull-downs where fitted, device drive when enabled
module rsc_board_model (
    // pins as the device sees them
    input  wire logic [24:0] pin_o,
    input  wire logic [24:0] pin_oe,
    // board population and resolved level
    input  wire logic [24:0] pulldown_fit,
    output logic      [24:0] pin_level
);
    // undriven pins float high, so only a fitted pull-down reads low
    assign pin_level = (pin_oe & pin_o) | (~pin_oe & ~pulldown_fit);
endmodule : rsc_board_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import rsc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lock = 0, ce = 1;
    logic [31:0] paddr = 0, pwdata = 0, prdata, cfg, rd;
    logic [24:0] pins_o, pins_oe, pins_i, pd = 0, exp_addr = 0;
    logic        pready, pslverr, captured, err;
    int          fail_count = 0, num_checks = 0;
    // 10 MHz
    always #50 pclk = ~pclk;
    rsc_strap_capture dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pll_lock_indication(lock),
        .strap_address_pins_i(pins_i), .strap_address_pins_o(pins_o),
        .strap_address_pins_oe(pins_oe), .exp_addr(exp_addr), .strap_cfg(cfg),
        .strap_captured(captured));
    rsc_board_model board_u (.pin_o(pins_o), .pin_oe(pins_oe), .pulldown_fit(pd),
        .pin_level(pins_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic do_reset(input logic [24:0] m);
        @(posedge pclk);
        pd <= m; presetn <= 0; lock <= 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        repeat (8) @(posedge pclk);
    endtask : do_reset
    // lock low: pins are inputs, config follows the pins with upper bits high, writes ignored
    task automatic scen_sample;
        chk(pins_oe, 0);
        chk(captured, 0);
        apb(1, RSC_STRAP_CFG_OFS, 32'h0);
        apb(0, RSC_STRAP_CFG_OFS, 0);
        chk(rd, {7'h7F, ~pd});
        apb(0, RSC_STATUS_OFS, 0);
        chk(rd, 32'h2);
    endtask : scen_sample
    // lock rises: straps land once, pins go back to driving
    task automatic scen_capture;
        int n;
        lock <= 1;
        for (n = 0; n < 30 && captured !== 1'b1; n++) @(posedge pclk);
        @(posedge pclk);
        chk(cfg, {7'h7F, ~pd});
        chk(pins_oe, RSC_STRAP_ONES);
        apb(0, RSC_STATUS_OFS, 0);
        chk(rd, 32'h1);
    endtask : scen_capture
    // run: bus address reaches the pins, straps no longer follow them
    task automatic scen_run;
        @(posedge pclk);
        ce <= 0;
        exp_addr <= 25'h0AA_5A5A;
        repeat (4) @(posedge pclk);
        chk(pins_o, 32'h0);
        ce <= 1;
        repeat (10) @(posedge pclk);
        chk(pins_o, 25'h0AA_5A5A);
        chk(cfg, {7'h7F, ~pd});
        apb(1, RSC_STRAP_CFG_OFS, {1'b0, 6'h3F, ~pd});
        apb(0, RSC_STRAP_CFG_OFS, 0);
        chk(rd, {1'b0, 6'h3F, ~pd});
        apb(1, RSC_STRAP_CFG_OFS, 32'h1234_5678);
        @(posedge pclk);
        chk(cfg, 32'h1234_5678);
        apb(0, 32'h0000_0010, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask : scen_run
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        #(100 * 3000);
        fail_count++;
        print_verdict();
    end
    initial begin
        do_reset(25'h0F0_F00F);
        scen_sample();
        scen_capture();
        scen_run();
        do_reset(25'h10B_0C21);
        scen_sample();
        scen_capture();
        print_verdict();
    end
endmodule : tb
